// ===== ssrc_routing.sv
// servo signal routing configuration: parameter registers, output polarity, pulse routing, command selection
// Summary of operation
// RULE1: control bits 8..12 set polarity of digital outputs 1..5; one inverts.
// RULE2: bit 13 passes received encoder A, B and index straight to the pulse outputs.
// RULE3: bit 14 passes only the received encoder index to the index output.
// RULE4: pass-through acts only with the reduced-wiring incremental encoder attached.
// RULE5: bit 15 reverses direction sense of generated A/B/index outputs.
// RULE6: reversal is ignored while bit 13 or bit 14 is set.
// RULE7: reference direction zero means counter-clockwise positive, one means clockwise.
// RULE8: feedback select 0x00 picks motor encoder, 0x01 external encoder.
// RULE9: external feedback gives position only; speed always comes from the motor encoder.
// RULE10: position command from link at 0x00, from pulse input at 0x01.
// RULE11: speed command from link at 0x00, from analog input at 0x01.
// RULE12: speed select bit 7 set (0x81) reverses analog speed polarity.
// RULE13: speed select 0x02 uses analog as limit; command comes from link.
// RULE14: analog limit mode applies the smaller of limit parameter and analog limit.
// RULE15: control switch resets to all zeros.
// RULE16: selector writes outside the documented set are dropped, old value kept.
//
// Chosen here: register access over Wishbone.
`default_nettype none
module ssrc_routing (
   input  wire  logic        clk,
   input  wire  logic        sys_rst,
   // classic wishbone slave
   input  wire  logic        wb_cyc_i,
   input  wire  logic        wb_stb_i,
   input  wire  logic        wb_we_i,
   input  wire  logic [9:0]  wb_adr_i,
   input  wire  logic [3:0]  wb_sel_i,
   input  wire  logic [31:0] wb_dat_i,
   output logic       [31:0] wb_dat_o,
   output logic              wb_ack_o,
   output logic              wb_err_o,
   // encoder side (asynchronous pins)
   input  wire  logic        encType,
   input  wire  logic        encPhaseA,
   input  wire  logic        encPhaseB,
   input  wire  logic        encIndex,
   // generated pulses from the internal divider (same clock)
   input  wire  logic        genPhaseA,
   input  wire  logic        genPhaseB,
   input  wire  logic        genIndex,
   output logic              quadrature_phase_a,
   output logic              quadrature_phase_b,
   output logic              indexOut,
   // digital outputs
   input  wire  logic [4:0]  outLevel,
   output logic              digital_output_1,
   output logic              digital_output_2,
   output logic              digital_output_3,
   output logic              digital_output_4,
   output logic              digital_output_5,
   // position and speed sources (same clock)
   input  wire  logic [31:0] motorEncPos,
   input  wire  logic [31:0] extEncPos,
   input  wire  logic [15:0] motorEncSpeed,
   input  wire  logic [31:0] linkPosCmd,
   input  wire  logic [31:0] pulsePosCmd,
   input  wire  logic [15:0] linkSpeedCmd,
   input  wire  logic [15:0] analogSpeed,
   output logic              directionClockwise,
   output logic       [31:0] feedbackPos,
   output logic       [15:0] feedbackSpeed,
   output logic       [31:0] positionCmd,
   output logic       [15:0] speedCmd,
   output logic       [15:0] speedLimit
);
   ////////////////////////////////////////////////////////////////////////////
   logic [15:0] controlSwitch_reg;
   logic [7:0]  referenceDir_reg;
   logic [7:0]  feedbackSel_reg;
   logic [7:0]  posCmdSel_reg;
   logic [7:0]  spdCmdSel_reg;
   logic [15:0] speedLimit_reg;
   logic        rejected_reg;
   logic [3:0]  encSync1_reg;
   logic [3:0]  encSync2_reg;
   logic        busReq;
   logic        wrEn;
   logic        mapped;
   logic [7:0]  wrByte0;
   logic [15:0] wrHalf;
   logic [31:0] rdData;

   assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign wrEn   = busReq && wb_we_i;
   // take byte lane 0 of the write data, zero when lane 0 is not selected
   assign wrByte0 = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;

   always_comb begin
      mapped = 1'b1;
      rdData = 32'h0000_0000;
      wrHalf = controlSwitch_reg;
      case (wb_adr_i)
         ssrc_pkg::ADDR_CONTROL_SWITCH: begin
            rdData = {16'h0000, controlSwitch_reg};
            wrHalf = {wb_sel_i[1] ? wb_dat_i[15:8] : controlSwitch_reg[15:8],
                      wb_sel_i[0] ? wb_dat_i[7:0] : controlSwitch_reg[7:0]};
         end
         ssrc_pkg::ADDR_REFERENCE_DIR:  rdData = {24'h000000, referenceDir_reg};
         ssrc_pkg::ADDR_FEEDBACK_SEL:   rdData = {24'h000000, feedbackSel_reg};
         ssrc_pkg::ADDR_POS_CMD_SEL:    rdData = {24'h000000, posCmdSel_reg};
         ssrc_pkg::ADDR_SPD_CMD_SEL:    rdData = {24'h000000, spdCmdSel_reg};
         ssrc_pkg::ADDR_SPEED_LIMIT: begin
            rdData = {16'h0000, speedLimit_reg};
            wrHalf = {wb_sel_i[1] ? wb_dat_i[15:8] : speedLimit_reg[15:8],
                      wb_sel_i[0] ? wb_dat_i[7:0] : speedLimit_reg[7:0]};
         end
         ssrc_pkg::ADDR_STATUS:         rdData = {28'h0000000, rejected_reg, encSync2_reg[3], 1'b0, 1'b0};
         default:                       mapped = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus answer: one wait-free cycle, ack or err the edge after the request
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= busReq && mapped;
         wb_err_o <= busReq && !mapped;
         wb_dat_o <= (busReq && !wb_we_i && mapped) ? rdData : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         controlSwitch_reg <= ssrc_pkg::CONTROL_SWITCH_RST; // RULE15
         speedLimit_reg    <= ssrc_pkg::SPEED_LIMIT_RST;
      end else if (wrEn && wb_adr_i == ssrc_pkg::ADDR_CONTROL_SWITCH) begin
         controlSwitch_reg <= wrHalf;
      end else if (wrEn && wb_adr_i == ssrc_pkg::ADDR_SPEED_LIMIT) begin
         speedLimit_reg    <= wrHalf;
      end
   end

   // selectors take a write only if the whole low byte is written with a legal value
   logic selWrite;
   logic legalVal;
   assign selWrite = wrEn && wb_sel_i[0];

   always_comb begin
      case (wb_adr_i)
         ssrc_pkg::ADDR_REFERENCE_DIR: legalVal = wrByte0 <= 8'h01;
         ssrc_pkg::ADDR_FEEDBACK_SEL:  legalVal = wrByte0 == ssrc_pkg::SEL_MOTOR_ENC
                                               || wrByte0 == ssrc_pkg::SEL_EXT_ENC;
         ssrc_pkg::ADDR_POS_CMD_SEL:   legalVal = wrByte0 == ssrc_pkg::SEL_LINK
                                               || wrByte0 == ssrc_pkg::SEL_PULSE;
         ssrc_pkg::ADDR_SPD_CMD_SEL:   legalVal = wrByte0 <= ssrc_pkg::SEL_ANALOG_LIMIT
                                               || wrByte0 == ssrc_pkg::SEL_ANALOG_REV;
         default:                      legalVal = 1'b0;
      endcase
   end

   logic isSelAddr;
   assign isSelAddr = wb_adr_i == ssrc_pkg::ADDR_REFERENCE_DIR || wb_adr_i == ssrc_pkg::ADDR_FEEDBACK_SEL
                   || wb_adr_i == ssrc_pkg::ADDR_POS_CMD_SEL || wb_adr_i == ssrc_pkg::ADDR_SPD_CMD_SEL;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         referenceDir_reg <= ssrc_pkg::REFERENCE_DIR_RST;
         feedbackSel_reg  <= ssrc_pkg::FEEDBACK_SEL_RST;
         posCmdSel_reg    <= ssrc_pkg::POS_CMD_SEL_RST;
         spdCmdSel_reg    <= ssrc_pkg::SPD_CMD_SEL_RST;
      end else if (selWrite && legalVal) begin
         case (wb_adr_i)
            ssrc_pkg::ADDR_REFERENCE_DIR: referenceDir_reg <= wrByte0;
            ssrc_pkg::ADDR_FEEDBACK_SEL:  feedbackSel_reg  <= wrByte0;
            ssrc_pkg::ADDR_POS_CMD_SEL:   posCmdSel_reg    <= wrByte0;
            ssrc_pkg::ADDR_SPD_CMD_SEL:   spdCmdSel_reg    <= wrByte0;
            default: ;
         endcase
      end
   end

   // sticky flag of the last refused selector write, cleared by writing a one to bit 3 of the status word
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rejected_reg <= 1'b0;
      end else if (wrEn && isSelAddr && !(wb_sel_i[0] && legalVal)) begin
         rejected_reg <= 1'b1; // RULE16
      end else if (wrEn && wb_adr_i == ssrc_pkg::ADDR_STATUS && wb_sel_i[0] && wb_dat_i[3]) begin
         rejected_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // encoder pins and type strap are asynchronous: two flops before use
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         encSync1_reg <= 4'h0;
         encSync2_reg <= 4'h0;
      end else begin
         encSync1_reg <= {encType, encIndex, encPhaseB, encPhaseA};
         encSync2_reg <= encSync1_reg;
      end
   end

   logic passAll;
   logic passIndex;
   logic reverseDir;
   assign passAll    = controlSwitch_reg[ssrc_pkg::CS_PASS_ALL_BIT] && encSync2_reg[3];          // RULE2 RULE4
   assign passIndex  = controlSwitch_reg[ssrc_pkg::CS_PASS_INDEX_BIT] && encSync2_reg[3];        // RULE3 RULE4
   // reversal swaps phases; blocked by either pass bit even when the encoder type disables them
   assign reverseDir = controlSwitch_reg[ssrc_pkg::CS_REVERSE_BIT]
                    && !controlSwitch_reg[ssrc_pkg::CS_PASS_ALL_BIT]
                    && !controlSwitch_reg[ssrc_pkg::CS_PASS_INDEX_BIT];                          // RULE5 RULE6

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         quadrature_phase_a <= 1'b0;
         quadrature_phase_b <= 1'b0;
         indexOut           <= 1'b0;
      end else begin
         if (passAll) begin
            quadrature_phase_a <= encSync2_reg[0]; // RULE2
            quadrature_phase_b <= encSync2_reg[1];
         end else begin
            quadrature_phase_a <= reverseDir ? genPhaseB : genPhaseA; // RULE5
            quadrature_phase_b <= reverseDir ? genPhaseA : genPhaseB;
         end
         indexOut <= (passAll || passIndex) ? encSync2_reg[2] : genIndex; // RULE3
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [4:0] outDrive_reg;
   genvar gi;
   generate
      for (gi = 0; gi < ssrc_pkg::NUM_OUTPUTS; gi++) begin : g_pol
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               outDrive_reg[gi] <= 1'b0;
            end else begin
               outDrive_reg[gi] <= outLevel[gi] ^ controlSwitch_reg[ssrc_pkg::CS_POL_LSB + gi]; // RULE1
            end
         end
      end
   endgenerate
   assign digital_output_1 = outDrive_reg[0];
   assign digital_output_2 = outDrive_reg[1];
   assign digital_output_3 = outDrive_reg[2];
   assign digital_output_4 = outDrive_reg[3];
   assign digital_output_5 = outDrive_reg[4];

   ////////////////////////////////////////////////////////////////////////////
   logic [15:0] analogSigned;
   logic [15:0] analogMag;
   assign analogSigned = spdCmdSel_reg[ssrc_pkg::SPD_REV_BIT] ? 16'(-analogSpeed) : analogSpeed; // RULE12
   // limit uses magnitude of analog input since it bounds both directions
   assign analogMag    = analogSpeed[15] ? 16'(-analogSpeed) : analogSpeed;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         directionClockwise <= 1'b0;
         feedbackPos        <= 32'h0000_0000;
         feedbackSpeed      <= 16'h0000;
         positionCmd        <= 32'h0000_0000;
         speedCmd           <= 16'h0000;
         speedLimit         <= 16'h0000;
      end else begin
         directionClockwise <= referenceDir_reg[0]; // RULE7
         feedbackPos   <= (feedbackSel_reg == ssrc_pkg::SEL_EXT_ENC) ? extEncPos : motorEncPos; // RULE8 RULE9
         feedbackSpeed <= motorEncSpeed; // RULE9
         positionCmd   <= (posCmdSel_reg == ssrc_pkg::SEL_PULSE) ? pulsePosCmd : linkPosCmd; // RULE10
         speedCmd      <= (spdCmdSel_reg == ssrc_pkg::SEL_ANALOG || spdCmdSel_reg == ssrc_pkg::SEL_ANALOG_REV)
                          ? analogSigned : linkSpeedCmd; // RULE11 RULE13
         if (spdCmdSel_reg == ssrc_pkg::SEL_ANALOG_LIMIT && analogMag < speedLimit_reg) begin
            speedLimit <= analogMag; // RULE14
         end else begin
            speedLimit <= speedLimit_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   AST_POLARITY: assert property (@(posedge clk) disable iff (sys_rst)
      digital_output_5 == ($past(outLevel[4]) ^ $past(controlSwitch_reg[12]))) else $error("output 5 polarity wrong"); // RULE1
   AST_PASS_ALL: assert property (@(posedge clk) disable iff (sys_rst)
      $past(passAll) |-> quadrature_phase_a == $past(encSync2_reg[0])) else $error("pass-through phase a wrong"); // RULE2
   AST_PASS_INDEX: assert property (@(posedge clk) disable iff (sys_rst)
      $past(passIndex) |-> indexOut == $past(encSync2_reg[2])) else $error("index pass wrong"); // RULE3
   AST_TYPE_GATE: assert property (@(posedge clk) disable iff (sys_rst)
      !$past(encSync2_reg[3]) |-> indexOut == $past(genIndex)) else $error("pass active with wrong encoder"); // RULE4
   AST_REVERSE: assert property (@(posedge clk) disable iff (sys_rst)
      $past(reverseDir) |-> quadrature_phase_a == $past(genPhaseB)) else $error("reversal wrong"); // RULE5
   AST_REV_BLOCK: assert property (@(posedge clk) disable iff (sys_rst)
      ($past(controlSwitch_reg[13] || controlSwitch_reg[14]) && !$past(passAll))
      |-> quadrature_phase_a == $past(genPhaseA)) else $error("reversal not blocked"); // RULE6
   AST_FEEDBACK: assert property (@(posedge clk) disable iff (sys_rst)
      $past(feedbackSel_reg) == 8'h01 |-> feedbackPos == $past(extEncPos) && feedbackSpeed == $past(motorEncSpeed))
      else $error("feedback source wrong"); // RULE9
   AST_LIMIT_MIN: assert property (@(posedge clk) disable iff (sys_rst)
      speedLimit <= $past(speedLimit_reg)) else $error("limit above parameter"); // RULE14
   AST_SEL_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
      (selWrite && wb_adr_i == ssrc_pkg::ADDR_FEEDBACK_SEL && wrByte0 > 8'h01) |=> $stable(feedbackSel_reg))
      else $error("illegal selector accepted"); // RULE16
   AST_ACK_DROP: assert property (@(posedge clk) disable iff (sys_rst)
      wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
   COV_PASS_ALL: cover property (@(posedge clk) disable iff (sys_rst) passAll);
   COV_REVERSE: cover property (@(posedge clk) disable iff (sys_rst) reverseDir);
   COV_LIMIT: cover property (@(posedge clk) disable iff (sys_rst) spdCmdSel_reg == 8'h02 && speedLimit < speedLimit_reg);
   COV_REJECT: cover property (@(posedge clk) disable iff (sys_rst) $rose(rejected_reg));
endmodule : ssrc_routing
`default_nettype wire

// ===== ssrc_pkg.sv
// constants shared by the servo signal routing configuration block
`default_nettype none
package ssrc_pkg;
   // register indices; the bus carries byte addresses, so byte address = 4 * index
   localparam logic [7:0] IDX_CONTROL_SWITCH  = 8'h45;
   localparam logic [7:0] IDX_REFERENCE_DIR   = 8'h48;
   localparam logic [7:0] IDX_FEEDBACK_SEL    = 8'h49;
   localparam logic [7:0] IDX_POS_CMD_SEL     = 8'h4a;
   localparam logic [7:0] IDX_SPD_CMD_SEL     = 8'h4b;
   localparam logic [7:0] IDX_SPEED_LIMIT     = 8'h58;
   localparam logic [7:0] IDX_STATUS          = 8'h60;
   localparam logic [9:0] ADDR_CONTROL_SWITCH = {IDX_CONTROL_SWITCH, 2'b00};
   localparam logic [9:0] ADDR_REFERENCE_DIR  = {IDX_REFERENCE_DIR, 2'b00};
   localparam logic [9:0] ADDR_FEEDBACK_SEL   = {IDX_FEEDBACK_SEL, 2'b00};
   localparam logic [9:0] ADDR_POS_CMD_SEL    = {IDX_POS_CMD_SEL, 2'b00};
   localparam logic [9:0] ADDR_SPD_CMD_SEL    = {IDX_SPD_CMD_SEL, 2'b00};
   localparam logic [9:0] ADDR_SPEED_LIMIT    = {IDX_SPEED_LIMIT, 2'b00};
   localparam logic [9:0] ADDR_STATUS         = {IDX_STATUS, 2'b00};
   // control switch fields
   localparam int         CS_POL_LSB          = 8;
   localparam int         CS_PASS_ALL_BIT     = 13;
   localparam int         CS_PASS_INDEX_BIT   = 14;
   localparam int         CS_REVERSE_BIT      = 15;
   localparam int         NUM_OUTPUTS         = 5;
   // reset values
   localparam logic [15:0] CONTROL_SWITCH_RST = 16'h0000;
   localparam logic [7:0]  REFERENCE_DIR_RST  = 8'h00;
   localparam logic [7:0]  FEEDBACK_SEL_RST   = 8'h00;
   localparam logic [7:0]  POS_CMD_SEL_RST    = 8'h00;
   localparam logic [7:0]  SPD_CMD_SEL_RST    = 8'h00;
   localparam logic [15:0] SPEED_LIMIT_RST    = 16'hffff;
   // selector encodings
   localparam logic [7:0] SEL_MOTOR_ENC       = 8'h00;
   localparam logic [7:0] SEL_EXT_ENC         = 8'h01;
   localparam logic [7:0] SEL_LINK            = 8'h00;
   localparam logic [7:0] SEL_PULSE           = 8'h01;
   localparam logic [7:0] SEL_ANALOG          = 8'h01;
   localparam logic [7:0] SEL_ANALOG_LIMIT    = 8'h02;
   localparam logic [7:0] SEL_ANALOG_REV      = 8'h81;
   localparam int         SPD_REV_BIT         = 7;
endpackage : ssrc_pkg
`default_nettype wire

// ===== ssrc_enc_model.sv
// behavioural incremental encoder on the far side of the routing block
`default_nettype none
module ssrc_enc_model (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic stepReq,
   input  wire logic reducedWiring,
   output logic      encType,
   output logic      encPhaseA,
   output logic      encPhaseB,
   output logic      encIndex
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] posReg;
   ////////////////////////////////////////////////////////////////////////////////
   // one quadrature step per request: a held request is the fastest rate, sparse ones are slow
   always_ff @(posedge clk) begin
      if (rst) begin
         posReg <= 3'h0;
      end else if (stepReq) begin
         posReg <= posReg + 3'h1;
      end
   end
   assign encType   = reducedWiring;
   assign encPhaseA = posReg[1];
   assign encPhaseB = posReg[1] ^ posReg[0];
   assign encIndex  = (posReg == 3'h0);
endmodule : ssrc_enc_model
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the servo signal routing block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, sysRst, wbCyc, wbStb, wbWe, wbAck, wbErr, encType, encA, encB, encIdx;
   logic        genA, genB, genIdx, qa, qb, idxOut, dirCw, stepReq, reducedWiring;
   logic [9:0]  wbAdr;
   logic [3:0]  wbSel;
   logic [31:0] wbDatI, wbDatO, motorPos, extPos, linkPos, pulsePos, fbPos, posCmd, rnd;
   logic [15:0] motorSpd, linkSpd, analogSpd, fbSpd, spdCmd, spdLim, lim, absA;
   logic [4:0]  outLevel, dout, pol;
   logic [2:0]  expQ;
   logic [33:0] note;
   logic [33:0] notes[$];
   logic [7:0]  modeTab[4] = '{8'h00, 8'h01, 8'h81, 8'h02};
   int          bad_count = 0, n_tests = 0, cycles = 0, i, j, k;
   ssrc_routing uut (.clk(clk), .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
      .wb_err_o(wbErr), .encType(encType), .encPhaseA(encA), .encPhaseB(encB), .encIndex(encIdx),
      .genPhaseA(genA), .genPhaseB(genB), .genIndex(genIdx), .quadrature_phase_a(qa),
      .quadrature_phase_b(qb), .indexOut(idxOut), .outLevel(outLevel), .digital_output_1(dout[0]),
      .digital_output_2(dout[1]), .digital_output_3(dout[2]), .digital_output_4(dout[3]),
      .digital_output_5(dout[4]), .motorEncPos(motorPos), .extEncPos(extPos), .motorEncSpeed(motorSpd),
      .linkPosCmd(linkPos), .pulsePosCmd(pulsePos), .linkSpeedCmd(linkSpd), .analogSpeed(analogSpd),
      .directionClockwise(dirCw), .feedbackPos(fbPos), .feedbackSpeed(fbSpd), .positionCmd(posCmd),
      .speedCmd(spdCmd), .speedLimit(spdLim));
   ssrc_enc_model encoder (.clk(clk), .rst(sysRst), .stepReq(stepReq), .reducedWiring(reducedWiring),
      .encType(encType), .encPhaseA(encA), .encPhaseB(encB), .encIndex(encIdx));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: output %h, expected %h", $time, got, exp);
      end
   endtask : check
   task automatic checkBus(input logic [33:0] n);
      n_tests++;
      if (wbErr !== n[32] || (n[33] && wbDatO !== n[31:0])) begin
         bad_count++;
         $display("wrong value at %0t: bus answer err %b data %h", $time, wbErr, wbDatO);
      end
   endtask : checkBus
   // request held until ack or err is sampled at a rising edge, then released
   task automatic wbCycle(input logic we, input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbSel <= 4'hf;
      wbDatI <= d;
      do @(posedge clk); while (wbAck !== 1'b1 && wbErr !== 1'b1);
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask : wbCycle
   task automatic wbWr(input logic [9:0] a, input logic [31:0] d);
      notes.push_back({2'b00, 32'h0});
      wbCycle(1'b1, a, d);
   endtask : wbWr
   task automatic wbRd(input logic [9:0] a, input logic [31:0] exp);
      notes.push_back({2'b10, exp});
      wbCycle(1'b0, a, 32'h0);
   endtask : wbRd
   // routed outputs need two sync edges plus one output edge at most
   task automatic settle;
      repeat (4) @(posedge clk);
   endtask : settle
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         summarize();
      end
      if (wbAck === 1'b1 || wbErr === 1'b1) begin
         if (notes.size() == 0) begin
            bad_count++;
            $display("wrong value at %0t: answer without request", $time);
         end else begin
            note = notes.pop_front();
            checkBus(note);
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI, genA, genB, genIdx, stepReq, reducedWiring} = '0;
      {outLevel, motorPos, extPos, linkPos, pulsePos, motorSpd, linkSpd, analogSpd} = '0;
      sysRst = 1'b1;
      rnd = $urandom(32'h3cd3);
      repeat (8) @(posedge clk);
      sysRst <= 1'b0;
      wbRd(ssrc_pkg::ADDR_CONTROL_SWITCH, 32'h0);
      wbRd(ssrc_pkg::ADDR_REFERENCE_DIR, 32'h0);
      wbRd(ssrc_pkg::ADDR_FEEDBACK_SEL, 32'h0);
      wbRd(ssrc_pkg::ADDR_POS_CMD_SEL, 32'h0);
      wbRd(ssrc_pkg::ADDR_SPD_CMD_SEL, 32'h0);
      wbRd(ssrc_pkg::ADDR_SPEED_LIMIT, {16'h0, ssrc_pkg::SPEED_LIMIT_RST});
      for (i = 0; i < 7; i++) begin
         pol = (i < 5) ? (5'h01 << i) : ((i == 5) ? 5'h1f : 5'h00);
         rnd = $urandom;
         outLevel <= rnd[4:0];
         wbWr(ssrc_pkg::ADDR_CONTROL_SWITCH, {19'h0, pol, 8'h00});
         settle();
         check({27'h0, dout}, {27'h0, outLevel ^ pol});
      end
      wbRd(ssrc_pkg::ADDR_CONTROL_SWITCH, 32'h0);
      // every combination of pass-all, pass-index, reverse and encoder type
      for (i = 0; i < 16; i++) begin
         reducedWiring <= i[3];
         wbWr(ssrc_pkg::ADDR_CONTROL_SWITCH, {16'h0, i[2:0], 13'h0});
         for (k = 0; k < 3; k++) begin
            rnd = $urandom;
            {genA, genB, genIdx} <= rnd[2:0];
            stepReq <= 1'b1;
            @(posedge clk);
            stepReq <= 1'b0;
            settle();
            if (i[3] && i[0]) expQ = {encA, encB, encIdx};
            else if (i[3] && i[1]) expQ = {genA, genB, encIdx};
            else if (i[2] && !i[0] && !i[1]) expQ = {genB, genA, genIdx};
            else expQ = {genA, genB, genIdx};
            check({29'h0, qa, qb, idxOut}, {29'h0, expQ});
         end
      end
      for (i = 0; i < 2; i++) begin
         {motorPos, extPos, linkPos, pulsePos} <= {$urandom, $urandom, $urandom, $urandom};
         rnd = $urandom;
         motorSpd <= rnd[15:0];
         wbWr(ssrc_pkg::ADDR_REFERENCE_DIR, i);
         wbWr(ssrc_pkg::ADDR_FEEDBACK_SEL, i);
         wbWr(ssrc_pkg::ADDR_POS_CMD_SEL, i);
         settle();
         check({31'h0, dirCw}, i);
         check(fbPos, i ? extPos : motorPos);
         check({16'h0, fbSpd}, {16'h0, motorSpd});
         check(posCmd, i ? pulsePos : linkPos);
      end
      rnd = $urandom;
      lim = rnd[15:0];
      wbWr(ssrc_pkg::ADDR_SPEED_LIMIT, {16'h0, lim});
      for (j = 0; j < 8; j++) begin
         rnd = $urandom;
         {analogSpd, linkSpd} <= rnd;
         wbWr(ssrc_pkg::ADDR_SPD_CMD_SEL, {24'h0, modeTab[j % 4]});
         settle();
         absA = analogSpd[15] ? -analogSpd : analogSpd;
         case (modeTab[j % 4])
            8'h01:   check({16'h0, spdCmd}, {16'h0, analogSpd});
            8'h81:   check({16'h0, spdCmd}, {16'h0, -analogSpd});
            default: check({16'h0, spdCmd}, {16'h0, linkSpd});
         endcase
         if (modeTab[j % 4] == 8'h02) check({16'h0, spdLim}, {16'h0, (lim < absA) ? lim : absA});
      end
      wbWr(ssrc_pkg::ADDR_FEEDBACK_SEL, 32'h02);
      wbRd(ssrc_pkg::ADDR_FEEDBACK_SEL, 32'h01);
      wbWr(ssrc_pkg::ADDR_SPD_CMD_SEL, 32'h03);
      wbRd(ssrc_pkg::ADDR_SPD_CMD_SEL, 32'h02);
      wbWr(ssrc_pkg::ADDR_REFERENCE_DIR, 32'h02);
      wbRd(ssrc_pkg::ADDR_REFERENCE_DIR, 32'h01);
      wbRd(ssrc_pkg::ADDR_STATUS, 32'h0000_000c);
      wbWr(ssrc_pkg::ADDR_STATUS, 32'h0000_0008);
      wbRd(ssrc_pkg::ADDR_STATUS, 32'h0000_0004);
      notes.push_back({2'b01, 32'h0});
      wbCycle(1'b0, 10'h3fc, 32'h0);
      repeat (3) @(posedge clk);
      summarize();
   end
endmodule : tb_top
`default_nettype wire
